// *** inc/rcw_consts.svh ***
`ifndef RCW_CONSTS_SVH
`define RCW_CONSTS_SVH

// ----------------------------------------------------------------
// timer configuration register fields
// ----------------------------------------------------------------
`define RCW_OPT_SRC_BIT 5
`define RCW_OPT_EDGE_BIT 4
`define RCW_OPT_ASSIGN_BIT 3
`define RCW_OPT_RATE_MSB 2
`define RCW_OPT_RATE_LSB 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RCW_RESET_VECTOR 11'h7FF
`define RCW_FLAGS_POR 2'b11
`define RCW_FLAGS_WDOG_SLEEP 2'b00
`define RCW_FLAGS_WDOG_ACTIVE 2'b01

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCW_CLK_HZ 25000000
`define RCW_WDOG_OSC_HZ 16000
`define RCW_WDOG_OSC_DIV (`RCW_CLK_HZ / `RCW_WDOG_OSC_HZ)

`endif

// *** inc/rcw_pkg.sv ***
package rcw_pkg;

	typedef logic [7:0] rcw_byte_t;

	// state of the prescaler module
	typedef struct packed {
		rcw_byte_t cnt;
	} rcw_psc_s;

	// state of the timer top
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		logic [10:0] osc_cnt;
		rcw_byte_t rtc;
		rcw_byte_t wdog;
		logic rtc_irq;
		logic wdog_rst;
		logic expired_st;
		logic asleep_st;
		logic [10:0] pc_vec;
	} rcw_top_s;

endpackage

// *** inc/rcw_psc_if.sv ***
`timescale 1ns/1ps
interface rcw_psc_if;
	logic tick;
	logic clear;
	logic [2:0] rate;
	logic wdog_mode;
	logic out_tick;

	modport master (output tick, output clear, output rate, output wdog_mode, input out_tick);
	modport scaler (input tick, input clear, input rate, input wdog_mode, output out_tick);
endinterface

// *** design/rcw_prescaler.sv ***
`timescale 1ns/1ps
module rcw_prescaler (
	input wire logic clk,
	input wire logic sys_rst,
	rcw_psc_if.scaler psc
);
	import rcw_pkg::*;

	rcw_psc_s q_r;
	rcw_psc_s q_nxt;
	logic [3:0] shift;
	rcw_byte_t mask;

	// low k bits set: ratio 2^k
	function automatic rcw_byte_t rcw_mask(input logic [3:0] k);
		logic [8:0] one_hot;
		one_hot = 9'h001 << k;
		return 8'(one_hot - 9'h001);
	endfunction

	// watchdog: 2^rate; real-time counter: 2^(rate+1), full 8 bits at top
	assign shift = psc.wdog_mode ? {1'b0, psc.rate} : ({1'b0, psc.rate} + 4'h1);
	assign mask = rcw_mask(shift);
	// clear is not read here: it depends on this output via the timeout, a loop
	assign psc.out_tick = psc.tick && ((q_r.cnt & mask) == mask);

	always_comb begin
		q_nxt = q_r;
		if (psc.clear) begin
			q_nxt.cnt = 8'h00;
		end else if (psc.tick) begin
			q_nxt.cnt = q_r.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule

// *** design/rcw_timer.sv ***
// Operation
// - 8-bit real-time counter steps on instruction cycles or external pin edges.
// - source bit clear selects instruction cycles, optionally through the prescaler.
// - source bit set counts valid transitions on the external count pin.
// - edge bit set counts falling edges, clear counts rising edges.
// - interrupt request raised when the real-time counter wraps from FF to 00.
// - no rollover flag latched; software reads the counter to see overflow.
// - one 8-bit prescaler extends the real-time counter to 16 bits.
// - 8-bit watchdog counter stepped by its own nominal 16 kHz oscillator.
// - watchdog reset issued on timeout only when the nonvolatile_config_word enable is 1.
// - assign bit set routes watchdog output through prescaler as postscaler.
// - assign bit clear routes count source through prescaler into real-time counter.
// - three rate bits pick the divide ratio for either counter.
// - prescaler count is never readable or writable by software.
// - prescaler serves one counter; the other runs undivided.
// - watchdog reset loads the program counter with top address 07FF.
// - watchdog reset sets expired/sleep flags 00 when asleep, 01 when active.
`timescale 1ns/1ps
`include "rcw_consts.svh"
module rcw_timer #(
	parameter int unsigned OSC_DIV = `RCW_WDOG_OSC_DIV
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_tick,
	input wire logic [7:0] option_cfg,
	input wire logic rtc_wr,
	input wire logic [7:0] rtc_wdata,
	input wire logic ext_count_pin,
	input wire logic watchdog_kick_instr,
	input wire logic sleep_mode,
	input wire logic watchdog_nonvolatile_config_word_enable,
	output rcw_pkg::rcw_byte_t real_time_counter,
	output logic rtc_irq,
	output logic watchdog_reset,
	output logic watchdog_expired_flag,
	output logic sleep_flag,
	output logic [10:0] pc_reset_vector
);
	import rcw_pkg::*;

	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	logic src_ext;
	logic edge_fall;
	logic prescaler_assign_bit;
	logic prescaler_rate_bit0;
	logic prescaler_rate_bit1;
	logic prescaler_rate_bit2;

	assign src_ext = option_cfg[`RCW_OPT_SRC_BIT];
	assign edge_fall = option_cfg[`RCW_OPT_EDGE_BIT];
	assign prescaler_assign_bit = option_cfg[`RCW_OPT_ASSIGN_BIT];
	assign prescaler_rate_bit0 = option_cfg[`RCW_OPT_RATE_LSB];
	assign prescaler_rate_bit1 = option_cfg[`RCW_OPT_RATE_LSB + 1];
	assign prescaler_rate_bit2 = option_cfg[`RCW_OPT_RATE_MSB];

	// ----------------------------------------------------------------
	// state and shared prescaler
	// ----------------------------------------------------------------
	rcw_top_s q_r;
	rcw_top_s q_nxt;
	rcw_psc_if psc_bus ();

	// prescaler has no software port at all, only this private link
	rcw_prescaler u_psc (
		.clk(clk),
		.sys_rst(sys_rst),
		.psc(psc_bus.scaler)
	);

	logic ext_edge;
	logic src_tick;
	logic osc_tick;
	logic wdog_ovf;
	logic timeout;
	logic wdog_fire;
	logic wdog_clear;
	logic rtc_inc;

	// ----------------------------------------------------------------
	// count source
	// ----------------------------------------------------------------
	// sync1 is read only by sync2; edges compare sync2 with sync3
	assign ext_edge = edge_fall ? (q_r.sync3 && !q_r.sync2)
		: (!q_r.sync3 && q_r.sync2);
	assign src_tick = src_ext ? ext_edge : instr_tick;

	// ----------------------------------------------------------------
	// watchdog oscillator and routing
	// ----------------------------------------------------------------
	// oscillator modelled as an enable from the system clock divider
	assign osc_tick = (q_r.osc_cnt == 11'(OSC_DIV - 1));
	assign wdog_ovf = osc_tick && (q_r.wdog == 8'hFF) && !watchdog_kick_instr;
	assign timeout = prescaler_assign_bit ? psc_bus.out_tick : wdog_ovf;
	assign wdog_fire = timeout && watchdog_nonvolatile_config_word_enable;
	assign wdog_clear = watchdog_kick_instr || wdog_fire;
	assign rtc_inc = prescaler_assign_bit ? src_tick : psc_bus.out_tick;

	assign psc_bus.tick = prescaler_assign_bit ? wdog_ovf : src_tick;
	assign psc_bus.clear = wdog_clear;
	assign psc_bus.rate = {prescaler_rate_bit2, prescaler_rate_bit1, prescaler_rate_bit0};
	assign psc_bus.wdog_mode = prescaler_assign_bit;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		q_nxt = q_r;
		q_nxt.sync1 = ext_count_pin;
		q_nxt.sync2 = q_r.sync1;
		q_nxt.sync3 = q_r.sync2;
		q_nxt.rtc_irq = 1'b0;
		q_nxt.wdog_rst = 1'b0;
		q_nxt.osc_cnt = osc_tick ? 11'h000 : (q_r.osc_cnt + 11'h001);
		if (wdog_clear) begin
			q_nxt.wdog = 8'h00;
		end else if (osc_tick) begin
			q_nxt.wdog = q_r.wdog + 8'h01;
		end
		if (wdog_fire) begin
			q_nxt.wdog_rst = 1'b1;
			q_nxt.pc_vec = `RCW_RESET_VECTOR;
			{q_nxt.expired_st, q_nxt.asleep_st} = sleep_mode ? `RCW_FLAGS_WDOG_SLEEP
				: `RCW_FLAGS_WDOG_ACTIVE;
		end
		// a core write beats a same-cycle increment
		if (rtc_wr) begin
			q_nxt.rtc = rtc_wdata;
		end else if (rtc_inc) begin
			q_nxt.rtc = q_r.rtc + 8'h01;
			q_nxt.rtc_irq = (q_r.rtc == 8'hFF);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q_r <= '0;
			{q_r.expired_st, q_r.asleep_st} <= `RCW_FLAGS_POR;
			q_r.pc_vec <= `RCW_RESET_VECTOR;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign real_time_counter = q_r.rtc;
	assign rtc_irq = q_r.rtc_irq;
	assign watchdog_reset = q_r.wdog_rst;
	assign watchdog_expired_flag = q_r.expired_st;
	assign sleep_flag = q_r.asleep_st;
	assign pc_reset_vector = q_r.pc_vec;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_wrap_step;
		rtc_inc && !rtc_wr && (q_r.rtc == 8'hFF);
	endsequence

	sequence s_wrap_seen;
		rtc_irq && (real_time_counter == 8'h00);
	endsequence

	a_rtc_wrap_irq: assert property (s_wrap_step |=> s_wrap_seen)
		else $error("wrap did not raise interrupt");

	a_irq_only_wrap: assert property (rtc_irq |-> $past(q_r.rtc) == 8'hFF
		&& real_time_counter == 8'h00 ##1 !rtc_irq)
		else $error("interrupt without wrap or held");

	a_int_source: assert property (!src_ext && prescaler_assign_bit && instr_tick && !rtc_wr
		|=> real_time_counter == $past(real_time_counter) + 8'h01)
		else $error("instruction cycle not counted");

	a_ext_edge: assert property (src_ext && prescaler_assign_bit && !edge_fall && !rtc_wr
		&& q_r.sync2 && !q_r.sync3
		|=> real_time_counter == $past(real_time_counter) + 8'h01)
		else $error("external rising edge not counted");

	a_ext_no_edge: assert property (src_ext && !ext_edge && !rtc_wr
		|=> $stable(real_time_counter))
		else $error("counter moved without edge");

	a_wdog_step: assert property (osc_tick && !wdog_clear
		|=> q_r.wdog == $past(q_r.wdog) + 8'h01)
		else $error("watchdog step wrong");

	a_wdog_hold: assert property (!osc_tick && !wdog_clear
		|=> $stable(q_r.wdog))
		else $error("watchdog moved without oscillator tick");

	a_nonvolatile_config_word_gate: assert property (!$past(watchdog_nonvolatile_config_word_enable) |-> !watchdog_reset)
		else $error("watchdog reset while nonvolatile_config_word disabled");

	a_wdog_flags: assert property (watchdog_reset |-> pc_reset_vector == `RCW_RESET_VECTOR
		&& {watchdog_expired_flag, sleep_flag} == ($past(sleep_mode)
		? `RCW_FLAGS_WDOG_SLEEP : `RCW_FLAGS_WDOG_ACTIVE))
		else $error("watchdog reset flags wrong");

	a_kick_clears: assert property (watchdog_kick_instr |=> q_r.wdog == 8'h00
		&& !watchdog_reset)
		else $error("kick did not clear watchdog");

	a_undivided_rtc: assert property (prescaler_assign_bit && src_tick && !rtc_wr
		|=> real_time_counter == $past(real_time_counter) + 8'h01)
		else $error("real-time counter divided while prescaler on watchdog");
endmodule

// *** bench/rcw_core_model.sv ***
`timescale 1ns/1ps
module rcw_core_model #(
	parameter int GAP = 300
) (
	input wire logic clk,
	input wire logic kick_en,
	output logic kick
);
	int n = 0;
	initial kick = 1'b0;
	// gap kept well under the shortest watchdog timeout
	always @(negedge clk) begin
		n = kick_en ? (n + 1) % GAP : 0;
		kick <= kick_en && (n == GAP - 1);
	end
endmodule

// *** bench/rcw_timer_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("mismatch %0t value differs", $time); end end
module rcw_timer_tb;
	import rcw_pkg::*;
	localparam int OSC = 2;
	logic clk, sys_rst, instr_tick, rtc_wr, ext_count_pin, sleep_mode, watchdog_nonvolatile_config_word_enable;
	logic kick_en, kick;
	logic [7:0] option_cfg, rtc_wdata;
	rcw_byte_t real_time_counter;
	logic rtc_irq, watchdog_reset, watchdog_expired_flag, sleep_flag;
	logic [10:0] pc_reset_vector;
	int errors = 0, checks_done = 0, cycles = 0, irqs = 0, wdrs = 0, k, w;

	rcw_timer #(.OSC_DIV(OSC)) uut (.clk(clk), .sys_rst(sys_rst), .instr_tick(instr_tick),
		.option_cfg(option_cfg), .rtc_wr(rtc_wr), .rtc_wdata(rtc_wdata),
		.ext_count_pin(ext_count_pin), .watchdog_kick_instr(kick), .sleep_mode(sleep_mode),
		.watchdog_nonvolatile_config_word_enable(watchdog_nonvolatile_config_word_enable), .real_time_counter(real_time_counter),
		.rtc_irq(rtc_irq), .watchdog_reset(watchdog_reset),
		.watchdog_expired_flag(watchdog_expired_flag), .sleep_flag(sleep_flag),
		.pc_reset_vector(pc_reset_vector));
	rcw_core_model core (.clk(clk), .kick_en(kick_en), .kick(kick));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		irqs += rtc_irq;
		wdrs += watchdog_reset;
		if (cycles == 40000) begin
			errors++;
			summarize();
		end
	end

	task summarize;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task rst;
		sys_rst = 1'b1;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
	endtask
	task ticks(input int n);
		repeat (n) begin
			@(negedge clk);
			instr_tick = 1'b1;
		end
		@(negedge clk);
		instr_tick = 1'b0;
		@(negedge clk);
	endtask
	task pulses(input int n);
		repeat (2 * n) begin
			repeat (2) @(negedge clk);
			ext_count_pin = ~ext_count_pin;
		end
		repeat (4) @(negedge clk);
	endtask
	// timeout clocks: postscaled only when the prescaler is assigned to the watchdog
	function int lim(input logic [7:0] c);
		return c[3] ? (256 << c[2:0]) * OSC : 256 * OSC;
	endfunction
	task wdog(input logic nonvolatile_config_word, input logic slp, input logic [7:0] c, input logic [1:0] fl);
		option_cfg = c;
		watchdog_nonvolatile_config_word_enable = nonvolatile_config_word;
		sleep_mode = slp;
		rst();
		w = wdrs;
		repeat (lim(c) - 8) @(negedge clk);
		`CHK(wdrs, w)
		repeat (16) @(negedge clk);
		`CHK(wdrs, w + int'(nonvolatile_config_word))
		if (nonvolatile_config_word) begin
			`CHK({watchdog_expired_flag, sleep_flag}, fl)
			`CHK(pc_reset_vector, 11'h7ff)
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{sys_rst, instr_tick, rtc_wr, ext_count_pin, sleep_mode, kick_en} = 6'h00;
		{watchdog_nonvolatile_config_word_enable, option_cfg, rtc_wdata} = 17'h0_0800;
		void'($urandom(3));
		rst();
		`CHK(real_time_counter, 8'h00)
		`CHK({watchdog_expired_flag, sleep_flag}, 2'b11)
		k = $urandom_range(40, 1);
		ticks(k);
		`CHK(real_time_counter, k[7:0])
		option_cfg = 8'h28;
		ticks(5);
		`CHK(real_time_counter, k[7:0])
		@(negedge clk);
		{rtc_wr, rtc_wdata} = 9'h1fe;
		@(negedge clk);
		{rtc_wr, option_cfg} = 9'h008;
		w = irqs;
		ticks(1);
		`CHK(irqs, w)
		ticks(1);
		`CHK(real_time_counter, 8'h00)
		`CHK(irqs, w + 1)
		for (int i = 0; i < 8; i++) begin
			option_cfg = i[7:0];
			rst();
			ticks((4 << i) - 1);
			`CHK(real_time_counter, 8'h01)
			ticks(1);
			`CHK(real_time_counter, 8'h02)
		end
		for (int e = 0; e < 2; e++) begin
			option_cfg = 8'h28 | (e[7:0] << 4);
			rst();
			k = $urandom_range(6, 1);
			pulses(k);
			`CHK(real_time_counter, k[7:0])
			ext_count_pin = 1'b1;
			repeat (6) @(negedge clk);
			`CHK(real_time_counter, 8'(k + 1 - e))
			ext_count_pin = 1'b0;
		end
		wdog(1'b1, 1'b0, 8'h08, 2'b01);
		wdog(1'b1, 1'b1, 8'h08 | 8'($urandom_range(2, 1)), 2'b00);
		wdog(1'b1, 1'b0, 8'h07, 2'b01);
		wdog(1'b0, 1'b0, 8'h08, 2'b11);
		watchdog_nonvolatile_config_word_enable = 1'b1;
		rst();
		kick_en = 1'b1;
		w = wdrs;
		repeat (2000) @(negedge clk);
		`CHK(wdrs, w)
		summarize();
	end
endmodule
